//--- src/acs_clock_selector.sv
// Audio sample clock source selector with AXI4-Lite registers
// Operation
// R01: Word clock output runs at the current sample rate by default.
// R02: Single-speed option folds word clock output into 32..48 kHz; code halves above 48k, quarters above 96k only.
// R03: Setting picks SPDIF receive source: coaxial or optical port 2.
// R04: SPDIF transmit always on coax; also on optical 2 when selected.
// R05: Word clock, optical 1, 2, SPDIF report no lock, lock or sync.
// R06: Clock mode picks master (internal) or automatic (external reference).
// R07: Automatic keeps preferred reference while valid, else next valid one.
// R08: Candidates: word clock, optical 1, 2, SPDIF, timecode, video.
// R09: Slave only when input rate matches current playback sample rate.
// R10: No valid candidate means internal clock, master behaviour.
// R11: Status shows master or slave clock state.
// R12: Status shows active reference identity and its measured frequency.
// R13: Lock to any reference rate from 28 kHz to 200 kHz.
// R14: At 88.2/96 kHz optical ports use sample split at half rate.
// R15: Synthesizer setting applies only in master mode.
// R16: Synth rate is base times multiplier plus active offset, 1 Hz steps.
// R17: Multiplier offers single, double and quad speed.
// R18: Synth enable gates all synth settings; clear means plain base rate.
// R19: Load copies nonvolatile settings in; store writes settings out.
// R20: Losing the active reference re-runs selection automatically.
// R21: Sync means rate matches reference within tolerance, period stable.
//
// The AXI4-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module acs_clock_selector
  import acs_pkg::*;
#(
  parameter int unsigned GATE_CYCLES = 40_000_000,
  parameter int ADDR_W = 8
)(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NUM_REF-1:0] ref_pins,
  input wire logic tco_present,
  input wire logic spdif_tx_data,
  input wire logic opt2_tx_data,
  input wire acs_cfg_t nv_rd_data,
  output logic wc_out,
  output logic spdif_coax_out,
  output logic opt2_out,
  output logic sample_split,
  output logic clk_slave,
  output logic nv_store_pulse,
  output acs_cfg_t nv_wr_data
);
  localparam int RW = 21;
  localparam int GW = $clog2(GATE_CYCLES + 1);

  // Rate compare within tolerance
  function automatic logic rate_near(input logic [RW-1:0] a,
                                     input logic [RW-1:0] b);
    logic [RW-1:0] d;
    d = (a > b) ? a - b : b - a;
    return d <= RW'(RATE_TOL_HZ);
  endfunction : rate_near

  // Byte-lane merge for register writes
  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] dat,
                                         input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (strb[b])
        r[8*b +: 8] = dat[8*b +: 8];
    return r;
  endfunction : wmerge

  acs_cfg_t cfg_ff;
  acs_state_t state_ff;
  logic [2:0] active_ff;
  logic [RW-1:0] int_rate_ff, cur_rate_ff, act_freq_ff;
  logic [NUM_REF-1:0] sync1_ff, sync2_ff, prev_ff;
  logic tco1_ff, tco2_ff;
  logic [NUM_REF-1:0] lock;
  logic [RW-1:0] freq_ff [NUM_REF];
  logic [RW-1:0] eff_freq [NUM_REF];
  logic [GW-1:0] gate_ff;
  logic [7:0] sync_st_ff;
  logic [26:0] acc_ff;
  logic awheld_ff, wheld_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;

  // Pin synchronisers
  always_ff @(posedge aclk)
  begin
    sync1_ff <= ref_pins;
    sync2_ff <= sync1_ff;
    tco1_ff <= tco_present;
    tco2_ff <= tco1_ff;
  end

  // SPDIF receive mux
  wire [NUM_REF-1:0] ref_s;
  assign ref_s[REF_SPDIF] = cfg_ff.ctrl.spdif_in_opt2 ?
                            sync2_ff[REF_OPT2] : sync2_ff[REF_SPDIF]; // R03
  assign ref_s[2:0] = sync2_ff[2:0];
  assign ref_s[5:4] = sync2_ff[5:4];

  always_ff @(posedge aclk)
  begin
    prev_ff <= aresetn ? ref_s : '0;
  end

  wire [NUM_REF-1:0] rise = ref_s & ~prev_ff;
  wire gate_end = (gate_ff == GW'(GATE_CYCLES - 1));

  // Measurement gate; edges per gate give the rate
  always_ff @(posedge aclk)
  begin
    if (!aresetn || gate_end)
      gate_ff <= '0;
    else
      gate_ff <= gate_ff + 1'b1;
  end

  // Playback rate decides optical sample split
  wire split = (int_rate_ff > RW'(WC_SS_MAX_HZ)) &&
               (int_rate_ff <= RW'(SPLIT_MAX_HZ)); // R14

  // Period tracker and frequency counter
  genvar gi;
  generate
    for (gi = 0; gi < NUM_REF; gi++)
    begin : g_ref
      logic [11:0] cnt_ff, per_ff;
      logic stable_ff;
      logic [RW-1:0] ecnt_ff;
      wire [11:0] pdiff = (cnt_ff > per_ff) ? cnt_ff - per_ff :
                          per_ff - cnt_ff;
      wire in_range = (cnt_ff >= 12'(MIN_PER)) &&
                      (cnt_ff <= 12'(MAX_PER)); // R13
      // Lock needs two matching periods inside the range
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          cnt_ff <= '0;
          per_ff <= '0;
          stable_ff <= 1'b0;
        end
        else if (rise[gi])
        begin
          cnt_ff <= 12'h001;
          per_ff <= cnt_ff;
          stable_ff <= in_range && (pdiff <= 12'(PER_TOL)); // R21
        end
        else if (cnt_ff != 12'hFFF)
          cnt_ff <= cnt_ff + 1'b1;
      end
      // A stopped input drops lock once a period overruns
      assign lock[gi] = stable_ff && (cnt_ff <= 12'(MAX_PER)); // R13
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          ecnt_ff <= '0;
          freq_ff[gi] <= '0;
        end
        else if (gate_end)
        begin
          ecnt_ff <= RW'(rise[gi]);
          freq_ff[gi] <= ecnt_ff;
        end
        else if (rise[gi])
          ecnt_ff <= ecnt_ff + 1'b1;
      end
      // Optical frames run at half rate in split mode
      if (gi == REF_OPT1 || gi == REF_OPT2)
      begin : g_opt
        assign eff_freq[gi] = split ? RW'({freq_ff[gi], 1'b0}) :
                              freq_ff[gi]; // R14
      end
      else
      begin : g_std
        assign eff_freq[gi] = freq_ff[gi];
      end
    end
  endgenerate

  // Candidates: locked, present, at playback rate
  wire [NUM_REF-1:0] avail = {tco2_ff, tco2_ff, 4'hF}; // R08
  wire [NUM_REF-1:0] ok;
  generate
    for (gi = 0; gi < NUM_REF; gi++)
    begin : g_ok
      assign ok[gi] = lock[gi] && avail[gi] &&
                      rate_near(eff_freq[gi], int_rate_ff); // R09
    end
  endgenerate

  // Lowest valid input is the fallback
  logic [2:0] first_ok;
  always_comb
  begin
    first_ok = REF_WC;
    for (int i = NUM_REF - 1; i >= 0; i--)
      if (ok[i])
        first_ok = 3'(i);
  end

  wire pref_ok = (cfg_ff.ctrl.pref < 3'(NUM_REF)) && ok[cfg_ff.ctrl.pref];
  wire [2:0] nxt_active = pref_ok ? cfg_ff.ctrl.pref : first_ok; // R07
  wire any_ok = |ok;
  // Re-evaluated every cycle, so a lost reference is left at once
  wire go_slave = cfg_ff.ctrl.auto_mode && any_ok; // R06 R10 R20
  acs_state_t nxt_state;
  always_comb
  begin
    unique case (state_ff)
      ST_MASTER: nxt_state = go_slave ? ST_SLAVE : ST_MASTER;
      ST_SLAVE: nxt_state = go_slave ? ST_SLAVE : ST_MASTER;
      default: nxt_state = ST_MASTER;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_ff <= ST_MASTER;
      active_ff <= REF_WC;
    end
    else
    begin
      state_ff <= nxt_state;
      active_ff <= go_slave ? nxt_active : REF_WC; // R07 R20
    end
  end

  // Internal rate; synth needs enable and master mode
  wire dds_on = cfg_ff.ctrl.dds_en && !cfg_ff.ctrl.auto_mode; // R15 R18
  wire [1:0] mult_sh = (cfg_ff.ctrl.mult == MULT_QUAD) ? 2'h2 :
                       (cfg_ff.ctrl.mult == MULT_DOUBLE) ? 2'h1 :
                       2'h0; // R17
  wire [RW:0] scaled = (RW + 1)'({3'h0, cfg_ff.base_hz} << mult_sh);
  wire [15:0] offs = cfg_ff.ctrl.coarse_act ? cfg_ff.coarse :
                     cfg_ff.ctrl.fine_act ? cfg_ff.fine : 16'h0000;
  wire signed [RW:0] synth = $signed(scaled) +
                             $signed({{(RW - 15){offs[15]}}, offs}); // R16
  wire [RW-1:0] synth_rate = synth[RW] ? '0 : synth[RW-1:0];
  wire [RW-1:0] nxt_int_rate = dds_on ? synth_rate :
                               RW'(cfg_ff.base_hz); // R16 R18
  wire [RW-1:0] nxt_act_freq = (state_ff == ST_SLAVE) ?
                               eff_freq[active_ff] : int_rate_ff; // R12

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      int_rate_ff <= RW'(BASE_RST_HZ);
      cur_rate_ff <= RW'(BASE_RST_HZ);
      act_freq_ff <= '0;
    end
    else
    begin
      int_rate_ff <= nxt_int_rate;
      act_freq_ff <= nxt_act_freq;
      cur_rate_ff <= nxt_act_freq;
    end
  end

  // Word clock rate, folded on request
  wire [RW-1:0] wc_rate = !cfg_ff.ctrl.wc_single ? cur_rate_ff :
    (cur_rate_ff > RW'(2 * WC_SS_MAX_HZ)) ? (cur_rate_ff >> 2) :
    (cur_rate_ff > RW'(WC_SS_MAX_HZ)) ? (cur_rate_ff >> 1) :
    cur_rate_ff; // R01 R02
  // Fractional divider: exact average rate, one-cycle edge jitter
  wire [26:0] acc_sum = acc_ff + 27'({wc_rate, 1'b0});
  wire wc_wrap = acc_sum >= 27'(CLK_HZ);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      acc_ff <= '0;
      wc_out <= 1'b0;
    end
    else
    begin
      acc_ff <= wc_wrap ? acc_sum - 27'(CLK_HZ) : acc_sum;
      wc_out <= wc_out ^ wc_wrap; // R01
    end
  end

  // Status for the four checked inputs
  logic [7:0] nxt_sync_st;
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      if (!lock[i])
        nxt_sync_st[2*i +: 2] = SYNC_NONE;
      else if (rate_near(eff_freq[i], cur_rate_ff))
        nxt_sync_st[2*i +: 2] = SYNC_SYNC; // R21
      else
        nxt_sync_st[2*i +: 2] = SYNC_LOCK; // R05
  end

  // Status and SPDIF routing flops
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync_st_ff <= '0;
      clk_slave <= 1'b0;
      sample_split <= 1'b0;
      spdif_coax_out <= 1'b0;
      opt2_out <= 1'b0;
    end
    else
    begin
      sync_st_ff <= nxt_sync_st; // R05
      clk_slave <= (nxt_state == ST_SLAVE); // R11
      sample_split <= split; // R14
      spdif_coax_out <= spdif_tx_data; // R04
      opt2_out <= cfg_ff.ctrl.spdif_out_opt2 ?
                  spdif_tx_data : opt2_tx_data; // R04
    end
  end

  // Write path: address and data in either order
  wire do_wr = awheld_ff && wheld_ff && !s_axi_bvalid;
  wire [7:0] wa = 8'(awaddr_ff);
  wire wr_ok = (wa == OFS_CTRL) || (wa == OFS_BASE) ||
               (wa == OFS_COARSE) || (wa == OFS_FINE) || (wa == OFS_CMD);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awheld_ff <= 1'b0;
      wheld_ff <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= AXI_OKAY;
      awaddr_ff <= '0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
    end
    else
    begin
      s_axi_awready <= !awheld_ff && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !wheld_ff && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready)
      begin
        awheld_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wheld_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (do_wr)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? AXI_OKAY : AXI_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        awheld_ff <= 1'b0;
        wheld_ff <= 1'b0;
      end
    end
  end

  // Settings, load and store
  wire cmd_wr = do_wr && (wa == OFS_CMD) && wstrb_ff[0];
  wire [31:0] ctrl_w = wmerge({20'h0_0000, cfg_ff.ctrl}, wdata_ff, wstrb_ff);
  wire [31:0] base_w = wmerge({14'h0000, cfg_ff.base_hz}, wdata_ff,
                              wstrb_ff);
  wire [31:0] crs_w = wmerge({16'h0000, cfg_ff.coarse}, wdata_ff, wstrb_ff);
  wire [31:0] fin_w = wmerge({16'h0000, cfg_ff.fine}, wdata_ff, wstrb_ff);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cfg_ff <= '{ctrl: '{mult: MULT_SINGLE, default: '0},
                  base_hz: BASE_RST_HZ, coarse: '0, fine: '0};
      nv_store_pulse <= 1'b0;
      nv_wr_data <= '0;
    end
    else
    begin
      nv_store_pulse <= cmd_wr && wdata_ff[CMD_STORE]; // R19
      if (cmd_wr && wdata_ff[CMD_STORE])
        nv_wr_data <= cfg_ff; // R19
      if (cmd_wr && wdata_ff[CMD_LOAD])
        cfg_ff <= nv_rd_data; // R19
      else if (do_wr && wa == OFS_CTRL)
        cfg_ff.ctrl <= acs_ctrl_t'(ctrl_w[11:0]); // R06 R03
      else if (do_wr && wa == OFS_BASE)
        cfg_ff.base_hz <= base_w[17:0];
      else if (do_wr && wa == OFS_COARSE)
        cfg_ff.coarse <= crs_w[15:0];
      else if (do_wr && wa == OFS_FINE)
        cfg_ff.fine <= fin_w[15:0];
    end
  end

  // Read decode
  wire [7:0] ra = 8'(s_axi_araddr);
  wire is_freq = (ra >= OFS_FREQ0) &&
                 (ra < OFS_FREQ0 + 8'(4 * NUM_REF)) && (ra[1:0] == 2'h0);
  wire [2:0] fsel = 3'((ra - OFS_FREQ0) >> 2);
  wire [31:0] status_w = {18'h0_0000, tco2_ff, sample_split,
                          sync_st_ff, active_ff, clk_slave}; // R11 R12
  wire rd_hit = is_freq || (ra == OFS_CTRL) || (ra == OFS_BASE) ||
                (ra == OFS_COARSE) || (ra == OFS_FINE) ||
                (ra == OFS_CMD) || (ra == OFS_STATUS) ||
                (ra == OFS_ACT_FREQ) || (ra == OFS_CUR_RATE);
  wire [31:0] rd_mux =
    is_freq ? 32'(freq_ff[fsel]) :
    (ra == OFS_CTRL) ? {20'h0_0000, cfg_ff.ctrl} :
    (ra == OFS_BASE) ? {14'h0000, cfg_ff.base_hz} :
    (ra == OFS_COARSE) ? {16'h0000, cfg_ff.coarse} :
    (ra == OFS_FINE) ? {16'h0000, cfg_ff.fine} :
    (ra == OFS_STATUS) ? status_w :
    (ra == OFS_ACT_FREQ) ? 32'(act_freq_ff) :
    (ra == OFS_CUR_RATE) ? 32'(int_rate_ff) : 32'h0000_0000;

  // AXI read path: one read at a time
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= AXI_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_hit ? AXI_OKAY : AXI_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
    else
      s_axi_arready <= !s_axi_rvalid;
  end
endmodule : acs_clock_selector
`default_nettype wire

//--- pkg/acs_pkg.sv
// Shared constants and types for the audio clock source selector
package acs_pkg;
  // System clock rate
  localparam int unsigned CLK_HZ = 40_000_000;
  // Reference inputs, in scan order
  localparam int NUM_REF = 6;
  localparam logic [2:0] REF_WC = 3'h0;
  localparam logic [2:0] REF_OPT1 = 3'h1;
  localparam logic [2:0] REF_OPT2 = 3'h2;
  localparam logic [2:0] REF_SPDIF = 3'h3;
  localparam logic [2:0] REF_LTC = 3'h4;
  localparam logic [2:0] REF_VIDEO = 3'h5;
  // Lock range and period bounds in cycles
  localparam int unsigned MIN_REF_HZ = 28_000;
  localparam int unsigned MAX_REF_HZ = 200_000;
  localparam int unsigned MIN_PER = CLK_HZ / MAX_REF_HZ;
  localparam int unsigned MAX_PER = (CLK_HZ + MIN_REF_HZ - 1) / MIN_REF_HZ;
  localparam int unsigned PER_TOL = 4;
  localparam int unsigned RATE_TOL_HZ = 200;
  // Single-speed band, also split threshold
  localparam int unsigned WC_SS_MIN_HZ = 32_000;
  localparam int unsigned WC_SS_MAX_HZ = 48_000;
  localparam int unsigned SPLIT_MAX_HZ = 2 * WC_SS_MAX_HZ + RATE_TOL_HZ;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_BASE = 8'h04;
  localparam logic [7:0] OFS_COARSE = 8'h08;
  localparam logic [7:0] OFS_FINE = 8'h0C;
  localparam logic [7:0] OFS_CMD = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_ACT_FREQ = 8'h18;
  localparam logic [7:0] OFS_CUR_RATE = 8'h1C;
  localparam logic [7:0] OFS_FREQ0 = 8'h20;
  // Command bits
  localparam int CMD_LOAD = 0;
  localparam int CMD_STORE = 1;
  // Reset values and encodings
  localparam logic [17:0] BASE_RST_HZ = 18'h0_BB80;
  localparam logic [1:0] MULT_SINGLE = 2'h0;
  localparam logic [1:0] MULT_DOUBLE = 2'h1;
  localparam logic [1:0] MULT_QUAD = 2'h2;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  // Control register layout, bit 0 is auto_mode
  typedef struct packed {
    logic fine_act;
    logic coarse_act;
    logic [1:0] mult;
    logic dds_en;
    logic spdif_out_opt2;
    logic spdif_in_opt2;
    logic wc_single;
    logic [2:0] pref;
    logic auto_mode;
  } acs_ctrl_t;
  // Settings image, also stored
  typedef struct packed {
    acs_ctrl_t ctrl;
    logic [17:0] base_hz;
    logic [15:0] coarse;
    logic [15:0] fine;
  } acs_cfg_t;
  typedef enum logic [1:0] {
    SYNC_NONE = 2'h0,
    SYNC_LOCK = 2'h1,
    SYNC_SYNC = 2'h2
  } acs_sync_t;
  typedef enum logic [1:0] {
    ST_MASTER = 2'h0,
    ST_SLAVE = 2'h1
  } acs_state_t;
endpackage : acs_pkg

//--- tb/acs_ref_model.sv
// Reference clock sources feeding the selector's reference pins
`timescale 1ns/10ps
`default_nettype none
module acs_ref_model
  import acs_pkg::*;
#(
  parameter int HALF_NS = 10417,
  parameter int FAST_HALF_NS = 100
)(
  input wire logic [NUM_REF-1:0] run,
  output logic [NUM_REF-1:0] ref_pins
);
  // One source per input; stopped ones idle low
  for (genvar i = 0; i < NUM_REF; i++)
  begin : g_src
    initial
    begin
      ref_pins[i] = 1'b0;
      forever
      begin
        if (run[i] === 1'b1)
        begin
          // Coax runs far above the lock range
          #((i == REF_SPDIF) ? FAST_HALF_NS : HALF_NS);
          ref_pins[i] = ~ref_pins[i] & run[i];
        end
        else
        begin
          ref_pins[i] = 1'b0;
          @(run[i]);
        end
      end
    end
  end
endmodule : acs_ref_model
`default_nettype wire

//--- tb/acs_clock_selector_asserts.sv
// Port-level checks for the clock source selector
`timescale 1ns/10ps
`default_nettype none
module acs_clock_selector_asserts
  import acs_pkg::*;
#(
  parameter int unsigned GATE_CYCLES = 40_000_000,
  parameter int ADDR_W = 8
)(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NUM_REF-1:0] ref_pins,
  input wire logic spdif_tx_data,
  input wire logic spdif_coax_out,
  input wire logic clk_slave,
  input wire logic nv_store_pulse
);
  // Slaving may outlast the last edge by the drop limit
  localparam int GAP_MAX = MAX_PER + 20;
  logic [NUM_REF-1:0] ref_q_ff;
  logic [15:0] gap_ff;
  wire logic [15:0] nxt_gap;
  wire logic ref_rise = |(ref_pins & ~ref_q_ff);
  assign nxt_gap = ref_rise ? 16'h0000 : gap_ff + {15'h0000, ~&gap_ff};
  // Cycles since any reference edge
  always_ff @(posedge aclk)
  begin
    ref_q_ff <= ref_pins;
    gap_ff <= aresetn ? nxt_gap : 16'h0000;
  end
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_reset_quiet;
    $rose(aresetn) |-> !clk_slave && !nv_store_pulse && !s_axi_bvalid
      && !s_axi_rvalid;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("busy after reset");
  property p_coax;
    $past(aresetn) && $past(aresetn, 2)
      |-> spdif_coax_out == $past(spdif_tx_data);
  endproperty
  a_coax: assert property (p_coax)
    else $error("coax mismatch");
  property p_store_one;
    nv_store_pulse |=> !nv_store_pulse;
  endproperty
  a_store_one: assert property (p_store_one)
    else $error("store pulse too long");
  property p_store_bus;
    nv_store_pulse |-> ##[0:1] s_axi_bvalid;
  endproperty
  a_store_bus: assert property (p_store_bus)
    else $error("store without write");
  property p_wr_resp;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> ##1 s_axi_bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp)
    else $error("write response late");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("bresp dropped");
  property p_aw_busy;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_aw_busy: assert property (p_aw_busy)
    else $error("second write accepted");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data dropped");
  property p_slave_gap;
    clk_slave |-> gap_ff < GAP_MAX;
  endproperty
  a_slave_gap: assert property (p_slave_gap)
    else $error("slave without edges");
  c_store: cover property (nv_store_pulse);
  c_slave: cover property ($rose(clk_slave));
  c_rwait: cover property (s_axi_rvalid && !s_axi_rready);
endmodule : acs_clock_selector_asserts
bind acs_clock_selector acs_clock_selector_asserts
  #(.GATE_CYCLES(GATE_CYCLES), .ADDR_W(ADDR_W)) u_acs_chk (.*);
`default_nettype wire

//--- tb/acs_clock_selector_tb.sv
// Self-checking bench for the audio clock source selector
`timescale 1ns/10ps
`default_nettype none
module acs_clock_selector_tb
  import acs_pkg::*;
;
  // Short gate: counts are edges per gate
  localparam int GATE = 5000;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd_v;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, wc_out, spdif_coax_out, opt2_out, sample_split;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [NUM_REF-1:0] ref_pins, run = 6'h00;
  logic tco_present = 1'b0, spdif_tx_data = 1'b0, opt2_tx_data = 1'b0;
  logic clk_slave, nv_store_pulse, wc_q = 1'b0;
  acs_cfg_t nv_rd_data = '0, nv_wr_data;
  logic [17:0] cap_base;
  int n_errors = 0, total_checks = 0, cyc = 0, n_store = 0, wc_cnt = 0;
  int wc_p = 0;
  acs_clock_selector #(.GATE_CYCLES(GATE)) dut_u (.*);
  acs_ref_model ref_u (.run(run), .ref_pins(ref_pins));
  initial
  begin
    forever #12.5 aclk = ~aclk;
  end
  // Timeout, word clock and store monitors
  always @(posedge aclk)
  begin
    cyc++;
    wc_q <= wc_out;
    wc_cnt <= (wc_out === 1'b1 && wc_q === 1'b0) ? 0 : wc_cnt + 1;
    if (wc_out === 1'b1 && wc_q === 1'b0)
      wc_p <= wc_cnt + 1;
    if (nv_store_pulse === 1'b1)
      n_store++;
    if (nv_store_pulse === 1'b1)
      cap_base <= nv_wr_data.base_hz;
    if (cyc == 60000)
    begin
      n_errors++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [31:0] got, e);
    total_checks++;
    if (got !== e)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, got);
    end
  endtask : chk
  task automatic end_sim;
    if (n_errors == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim
  // Address and data together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_awvalid || s_axi_wvalid);
    while (s_axi_bvalid !== 1'b1)
      @(posedge aclk);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  // Late ready exercises the read data hold
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    rd_v = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic t_synth;
    logic [11:0] c [9] = '{12'h200, 12'h080, 12'h180, 12'h280, 12'h380,
      12'h480, 12'h880, 12'hC80, 12'h181};
    logic [17:0] r [9] = '{18'h0_BB80, 18'h0_BB80, 18'h1_7700, 18'h2_EE00,
      18'h0_BB80, 18'h0_BB1C, 18'h0_BB85, 18'h0_BB1C, 18'h0_BB80};
    wr(OFS_COARSE, 32'h0000_FF9C);
    wr(OFS_FINE, 32'h0000_0005);
    for (int i = 0; i < 9; i++)
    begin
      wr(OFS_CTRL, {20'h0_0000, c[i]});
      rd(OFS_CUR_RATE);
      chk("rate", rd_v, r[i]);
      chk("split", sample_split,
          r[i] > WC_SS_MAX_HZ && r[i] <= SPLIT_MAX_HZ);
    end
  endtask : t_synth
  task automatic t_wc;
    logic [11:0] c [3] = '{12'h080, 12'h180, 12'h190};
    int lo [3] = '{832, 416, 832};
    for (int i = 0; i < 3; i++)
    begin
      wr(OFS_CTRL, {20'h0_0000, c[i]});
      repeat (2000) @(posedge aclk);
      chk("wc period", wc_p >= lo[i] && wc_p <= lo[i] + 2, 1'b1);
    end
  endtask : t_wc
  task automatic t_spdif;
    for (int s = 0; s < 2; s++)
    begin
      wr(OFS_CTRL, s ? 32'h0000_0040 : 32'h0000_0000);
      for (int v = 0; v < 4; v++)
      begin
        spdif_tx_data <= v[0];
        opt2_tx_data <= v[1];
        @(posedge aclk);
        @(negedge aclk);
        chk("coax", spdif_coax_out, v[0]);
        chk("opt2", opt2_out, s ? v[0] : v[1]);
        @(posedge aclk);
      end
    end
  endtask : t_spdif
  task automatic t_nv;
    wr(OFS_BASE, 32'h0000_04D2);
    wr(OFS_CMD, 32'h0000_0002);
    repeat (3) @(posedge aclk);
    chk("stores", n_store, 1);
    chk("stored base", cap_base, 18'h0_04D2);
    nv_rd_data <= {12'h010, 18'h0_0309, 32'h0000_0000};
    wr(OFS_CMD, 32'h0000_0001);
    rd(OFS_BASE);
    chk("loaded base", rd_v, 32'h0000_0309);
    rd(OFS_CTRL);
    chk("loaded ctrl", rd_v, 32'h0000_0010);
  endtask : t_nv
  // Status read, active reference check
  task automatic st(input logic [2:0] id, input string nm);
    repeat (10) @(posedge aclk);
    rd(OFS_STATUS);
    chk(nm, rd_v[3:0], {id, 1'b1});
  endtask : st
  task automatic t_sync;
    wr(OFS_BASE, 32'h0000_BB80);
    wr(OFS_CTRL, 32'h0000_0009);
    run <= 6'h1B;
    repeat (3 * GATE) @(posedge aclk);
    chk("rate mismatch", clk_slave, 1'b0);
    rd(OFS_STATUS);
    chk("wc lock", rd_v[5:4], SYNC_LOCK);
    chk("fast spdif", rd_v[11:10], SYNC_NONE);
    wr(OFS_BASE, 32'h0000_0006);
    st(REF_WC, "fallback id");
    chk("wc sync", rd_v[5:4], SYNC_SYNC);
    chk("opt2 none", rd_v[9:8], SYNC_NONE);
    rd(OFS_ACT_FREQ);
    chk("act freq", rd_v >= 5 && rd_v <= 7, 1'b1);
    tco_present <= 1'b1;
    st(REF_LTC, "timecode id");
    tco_present <= 1'b0;
    wr(OFS_CTRL, 32'h0000_0003);
    st(REF_OPT1, "preferred id");
    run <= 6'h01;
    repeat (1600) @(posedge aclk);
    st(REF_WC, "lost pref id");
    chk("opt1 none", rd_v[7:6], SYNC_NONE);
    wr(OFS_CTRL, 32'h0000_0002);
    repeat (10) @(posedge aclk);
    chk("master mode", clk_slave, 1'b0);
    run <= 6'h05;
    wr(OFS_CTRL, 32'h0000_0023);
    repeat (2500) @(posedge aclk);
    rd(OFS_STATUS);
    chk("spdif via opt2", rd_v[11:10] != 2'h0, 1'b1);
    run <= 6'h00;
    repeat (1600) @(posedge aclk);
    chk("no ref slave", clk_slave, 1'b0);
    rd(OFS_STATUS);
    chk("no ref status", rd_v[0], 1'b0);
  endtask : t_sync
  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFS_CTRL);
    chk("ctrl reset", rd_v, 32'h0000_0000);
    rd(8'h40);
    chk("unmapped", resp, AXI_SLVERR);
    wr(OFS_STATUS, 32'h0000_0001);
    chk("ro write", resp, AXI_SLVERR);
    t_synth();
    t_wc();
    t_spdif();
    t_nv();
    t_sync();
    end_sim();
  end
endmodule : acs_clock_selector_tb
`default_nettype wire
